// >>> include/pc_seq_cfg.svh
// Constants for the program-counter sequencing unit.
// Assumes inclusion by bare name from the design file.
`ifndef PC_SEQ_CFG_SVH
`define PC_SEQ_CFG_SVH

`define PC_W 13
`define PC_LOW_W 8
`define PC_UP_W 5
`define TARGET_W 11
`define STACK_DEPTH 8
`define SP_W 3
`define DADDR_W 9

`define OFF_PC_LOW_BYTE 4'h0
`define OFF_PC_HIGH_LATCH 4'h4
`define OFF_FILE_POINTER 4'h8
`define OFF_BANK_STATUS 4'hc

`define BANK_BIT_POS 7
`define PAGE_LO_POS 3
`define PAGE_HI_POS 4

`define PC_RESET 13'h0000
`define LATCH_RESET 5'h00
`define FP_RESET 8'h00
`define IRQ_VECTOR 13'h0004
`define INDIRECT_PORT_ADDR 7'h00

`define BUS_WAIT_CYCLES 1

`endif

// >>> include/pc_seq_pkg.sv
// Types shared by the program-counter sequencing unit.
// Assumes the core presents one decoded operation per executed instruction.
package pc_seq_pkg;

  typedef enum logic [2:0] {
    op_next,
    op_jump,
    op_call,
    op_return,
    op_return_with_literal,
    op_return_from_interrupt,
    op_interrupt,
    op_pc_low_write
  } seq_op_t;

endpackage

// >>> rtl/pc_stack_paging_indirect.sv
// Program-counter sequencing unit: program counter, circular return stack,
// page latch and indirect data addressing, with an Avalon-MM register slave.
// Assumes the core, bus master and register file share clock and rst.
//
// Behaviour
// - Eight 13-bit stack entries, hidden pointer.
// - Push PC on call or interrupt.
// - Pop into PC on any return.
// - Push and pop leave latch unchanged.
// - Stack wraps circularly, overwriting oldest entries.
// - No overflow or underflow indication.
// - 8K-word space, 11-bit branch targets.
// - Call/jump upper bits from latch 4:3.
// - Full 13-bit PC saved; call saves PC+1, interrupt saves PC.
// - Small variants ignore latch bit 4.
// - Low-byte write makes a computed jump.
// - Indirect port accesses register at pointer.
// - Indirect self write changes nothing.
// - Indirect address is bank bit over pointer.
// - 13-bit PC, upper bits write-only via latch.
// - Low-byte write loads upper from latch.
// - Reset clears the program counter.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "pc_seq_cfg.svh"
`default_nettype none

module pc_stack_paging_indirect
  import pc_seq_pkg::*;
#(
  parameter bit wide_memory = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  // Core sequencing side.
  input wire logic exec,
  input wire seq_op_t op,
  input wire logic [`TARGET_W-1:0] target,
  input wire logic [`PC_LOW_W-1:0] pc_low_data,
  output logic [`PC_W-1:0] prog_addr,
  // Core data access side.
  input wire logic [`DADDR_W-1:0] dp_addr,
  input wire logic dp_rd,
  input wire logic dp_wr,
  input wire logic [7:0] dp_wdata,
  output logic [7:0] dp_rdata,
  // Register file side.
  output logic [`DADDR_W-1:0] rf_addr,
  output logic rf_rd,
  output logic rf_wr,
  output logic [7:0] rf_wdata,
  input wire logic [7:0] rf_rdata,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // Indirect port decode, shared by the read and the write path.
  function automatic logic is_indirect(input logic [`DADDR_W-1:0] a);
    is_indirect = (a[6:0] == `INDIRECT_PORT_ADDR);
  endfunction

  logic [`PC_W-1:0] pc_ff;
  logic [`PC_W-1:0] nxt_pc;
  logic [`PC_UP_W-1:0] latch_ff;
  logic [7:0] fp_ff;
  logic bank_ff;
  logic [`SP_W-1:0] sp_ff;
  logic [`SP_W-1:0] nxt_sp;
  logic [`PC_W-1:0] stack_ff [`STACK_DEPTH];
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [`DADDR_W-1:0] rf_addr_ff;
  logic rf_rd_ff;
  logic rf_wr_ff;
  logic [7:0] rf_wdata_ff;
  logic self_rd_ff;
  logic [7:0] dp_rdata_ff;

  // Bus decode.
  // A write lands at the edge that takes it; the master holds the request
  // under waitrequest and cannot withdraw it, so nothing is lost by this.
  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & ~ack_ff;
  wire bus_wr = avs_write & bus_take & avs_byteenable[0];
  wire wr_pcl = bus_wr & (avs_address == `OFF_PC_LOW_BYTE);
  wire wr_latch = bus_wr & (avs_address == `OFF_PC_HIGH_LATCH);
  wire wr_fp = bus_wr & (avs_address == `OFF_FILE_POINTER);
  wire wr_bank = bus_wr & (avs_address == `OFF_BANK_STATUS);

  // Effective latch: bit 4 is dropped on small-memory variants.
  wire [`PC_UP_W-1:0] eff_latch = {latch_ff[`PAGE_HI_POS] & wide_memory,
                                  latch_ff[3:0]};
  wire [1:0] page_bits = eff_latch[`PAGE_HI_POS:`PAGE_LO_POS];

  // Sequencing decode.
  wire do_push = exec & ((op == op_call) | (op == op_interrupt));
  wire do_pop = exec & ((op == op_return) | (op == op_return_with_literal)
                        | (op == op_return_from_interrupt));
  wire [`SP_W-1:0] sp_dec = nxt_sp_dec(sp_ff);
  wire [`PC_W-1:0] stack_top = stack_ff[sp_dec];
  wire [`PC_W-1:0] pc_inc = pc_ff + `PC_W'(1);
  wire [`PC_W-1:0] branch_pc = {page_bits, target};
  // A call returns past itself; an interrupt resumes the preempted word.
  wire [`PC_W-1:0] push_val = (op == op_call) ? pc_inc : pc_ff;

  function automatic logic [`SP_W-1:0] nxt_sp_dec(input logic [`SP_W-1:0] s);
    nxt_sp_dec = s - `SP_W'(1);
  endfunction

  always_comb begin
    nxt_pc = pc_inc;
    nxt_sp = sp_ff;
    if (exec) begin
      unique case (op)
        op_next: begin
          nxt_pc = pc_inc;
        end
        op_jump: begin
          nxt_pc = branch_pc;
        end
        op_call: begin
          nxt_pc = branch_pc;
          nxt_sp = sp_ff + `SP_W'(1);
        end
        op_interrupt: begin
          nxt_pc = `IRQ_VECTOR;
          nxt_sp = sp_ff + `SP_W'(1);
        end
        op_return, op_return_with_literal, op_return_from_interrupt: begin
          nxt_pc = stack_top;
          nxt_sp = sp_dec;
        end
        op_pc_low_write: begin
          nxt_pc = {eff_latch, pc_low_data};
        end
      endcase
    end else begin
      nxt_pc = pc_ff;
    end
    // A bus write of the low byte is a computed jump as well.
    if (wr_pcl) begin
      nxt_pc = {eff_latch, avs_writedata[7:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_ff <= `PC_RESET;
      sp_ff <= '0;
    end else begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
    end
  end

  // Stack entries; not reset, so a pop with no earlier push to that entry reads an unwritten value.
  genvar gi;
  generate
    for (gi = 0; gi < `STACK_DEPTH; gi++) begin : g_stack
      always_ff @(posedge clock) begin
        if (do_push && sp_ff == `SP_W'(gi)) begin
          stack_ff[gi] <= push_val;
        end
      end
    end
  endgenerate

  // Software-visible registers; stack traffic never touches the latch.
  always_ff @(posedge clock) begin
    if (rst) begin
      latch_ff <= `LATCH_RESET;
      fp_ff <= `FP_RESET;
      bank_ff <= 1'b0;
    end else begin
      if (wr_latch) begin
        latch_ff <= avs_writedata[`PC_UP_W-1:0];
      end
      if (wr_fp) begin
        fp_ff <= avs_writedata[7:0];
      end
      if (wr_bank) begin
        bank_ff <= avs_writedata[`BANK_BIT_POS];
      end
    end
  end

  // Register read mux; upper PC bits are deliberately not readable.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      `OFF_PC_LOW_BYTE: rd_mux = {24'h0, pc_ff[7:0]};
      `OFF_PC_HIGH_LATCH: rd_mux = {27'h0, latch_ff};
      `OFF_FILE_POINTER: rd_mux = {24'h0, fp_ff};
      `OFF_BANK_STATUS: rd_mux = {24'h0, bank_ff, 7'h00};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= bus_take;
      if (avs_read && bus_take) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = bus_req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // Indirect data addressing.
  wire dp_ind = is_indirect(dp_addr);
  wire [`DADDR_W-1:0] ind_addr = {bank_ff, fp_ff};
  wire ind_self = is_indirect(ind_addr);
  wire [`DADDR_W-1:0] eff_addr = dp_ind ? ind_addr : dp_addr;
  wire self_hit = dp_ind & ind_self;

  always_ff @(posedge clock) begin
    if (rst) begin
      rf_addr_ff <= '0;
      rf_rd_ff <= 1'b0;
      rf_wr_ff <= 1'b0;
      rf_wdata_ff <= 8'h00;
      self_rd_ff <= 1'b0;
      dp_rdata_ff <= 8'h00;
    end else begin
      rf_addr_ff <= eff_addr;
      rf_rd_ff <= dp_rd & ~self_hit;
      rf_wr_ff <= dp_wr & ~self_hit;
      rf_wdata_ff <= dp_wdata;
      self_rd_ff <= dp_rd & self_hit;
      if (self_rd_ff) begin
        dp_rdata_ff <= 8'h00;
      end else if (rf_rd_ff) begin
        dp_rdata_ff <= rf_rdata;
      end
    end
  end

  assign prog_addr = pc_ff;
  assign rf_addr = rf_addr_ff;
  assign rf_rd = rf_rd_ff;
  assign rf_wr = rf_wr_ff;
  assign rf_wdata = rf_wdata_ff;
  assign dp_rdata = dp_rdata_ff;

  // Checks.
  property p_push_moves_pointer;
    @(posedge clock) disable iff (rst)
    do_push |=> sp_ff == $past(sp_ff) + `SP_W'(1);
  endproperty
  a_push_moves_pointer: assert property (p_push_moves_pointer)
    else $error("Stack pointer did not advance on push.");

  property p_push_stores_pc;
    @(posedge clock) disable iff (rst)
    (exec && op == op_call && !wr_pcl) |=> stack_ff[$past(sp_ff)] == $past(pc_ff) + `PC_W'(1);
  endproperty
  a_push_stores_pc: assert property (p_push_stores_pc)
    else $error("Call did not save the full return address.");

  property p_call_then_return;
    @(posedge clock) disable iff (rst)
    (exec && op == op_call && !wr_pcl) ##1 (exec && op == op_return && !wr_pcl)
      |=> pc_ff == $past(pc_ff, 2) + `PC_W'(1);
  endproperty
  a_call_then_return: assert property (p_call_then_return)
    else $error("Return did not restore the call's return address.");

  property p_latch_kept;
    @(posedge clock) disable iff (rst)
    ((do_push || do_pop) && !wr_latch) |=> $stable(latch_ff);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("Stack operation changed the page latch.");

  property p_jump_page;
    @(posedge clock) disable iff (rst)
    (exec && op == op_jump && !wr_pcl)
      |=> pc_ff == {$past(page_bits), $past(target)};
  endproperty
  a_jump_page: assert property (p_jump_page)
    else $error("Jump target not formed from page bits and target.");

  property p_low_write_upper;
    @(posedge clock) disable iff (rst)
    wr_pcl |=> pc_ff[`PC_W-1:`PC_LOW_W] == $past(eff_latch)
      && pc_ff[7:0] == $past(avs_writedata[7:0]);
  endproperty
  a_low_write_upper: assert property (p_low_write_upper)
    else $error("Low-byte write did not load upper bits from the latch.");

  property p_reset_clears;
    @(posedge clock) rst |=> pc_ff == `PC_RESET;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("Reset did not clear the program counter.");

  property p_step;
    @(posedge clock) disable iff (rst)
    (exec && op == op_next && !wr_pcl) |=> pc_ff == $past(pc_ff) + `PC_W'(1);
  endproperty
  a_step: assert property (p_step)
    else $error("Program counter did not advance by one.");

  property p_self_read_zero;
    @(posedge clock) disable iff (rst)
    (dp_rd && self_hit) |=> !rf_rd ##1 dp_rdata == 8'h00;
  endproperty
  a_self_read_zero: assert property (p_self_read_zero)
    else $error("Indirect self read did not return zero.");

  property p_self_write_nop;
    @(posedge clock) disable iff (rst)
    (dp_wr && self_hit) |=> !rf_wr;
  endproperty
  a_self_write_nop: assert property (p_self_write_nop)
    else $error("Indirect self write reached the register file.");

  property p_indirect_addr;
    @(posedge clock) disable iff (rst)
    (dp_ind && (dp_rd || dp_wr)) |=> rf_addr == {$past(bank_ff), $past(fp_ff)};
  endproperty
  a_indirect_addr: assert property (p_indirect_addr)
    else $error("Indirect address not formed from bank bit and pointer.");

endmodule

`default_nettype wire

// >>> dv/reg_file_model.sv
// Behavioural register file on the far side of the data port.
// Assumes one rf_* request per cycle, sampled on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire logic clock,
  input wire logic [8:0] rf_addr,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata
);
  logic [7:0] mem [512];
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  // Outside a read the lines show the inverse, so stale data never matches.
  assign rf_rdata = rf_rd ? mem[rf_addr] : ~mem[rf_addr];
  always @(posedge clock) begin
    if (rf_wr) begin
      mem[rf_addr] <= rf_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the program-counter sequencing unit.
// Assumes the register file model stands on the rf_* side.
`timescale 1ns/1ps
`include "pc_seq_cfg.svh"
`default_nettype none
module tb_top;
  import pc_seq_pkg::*;
  logic clock, rst, exec, dp_rd, dp_wr, avs_read, avs_write, avs_waitrequest, rf_rd, rf_wr;
  seq_op_t op;
  seq_op_t rets [3] = '{op_return, op_return_with_literal, op_return_from_interrupt};
  logic [10:0] target;
  logic [7:0] pc_low_data, dp_wdata, dp_rdata, rf_wdata, rf_rdata;
  logic [12:0] prog_addr, epc, prog_addr_small;
  logic [12:0] estk [8];
  logic [2:0] esp;
  logic [8:0] dp_addr, rf_addr;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int n_mismatch, n_checks, n_rfwr;

  pc_stack_paging_indirect dut (.clock(clock), .rst(rst), .exec(exec), .op(op),
    .target(target), .pc_low_data(pc_low_data), .prog_addr(prog_addr),
    .dp_addr(dp_addr), .dp_rd(dp_rd), .dp_wr(dp_wr), .dp_wdata(dp_wdata),
    .dp_rdata(dp_rdata), .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr),
    .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // Small-memory variant on the same stimulus; only its program counter is watched.
  pc_stack_paging_indirect #(.wide_memory(1'b0)) dut_small (.clock(clock), .rst(rst),
    .exec(exec), .op(op), .target(target), .pc_low_data(pc_low_data),
    .prog_addr(prog_addr_small), .dp_addr(dp_addr), .dp_rd(dp_rd), .dp_wr(dp_wr),
    .dp_wdata(dp_wdata), .dp_rdata(), .rf_addr(), .rf_rd(), .rf_wr(), .rf_wdata(),
    .rf_rdata(rf_rdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(), .avs_waitrequest());
  reg_file_model rf (.clock(clock), .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr),
    .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));

  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rf_wr === 1'b1) n_rfwr++;
  end

  task test_done;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (i == 20) begin
      n_mismatch++;
      test_done;
    end
  endtask

  task core(input seq_op_t o, input logic [10:0] t, input logic [7:0] d);
    @(posedge clock);
    exec <= 1;
    op <= o;
    target <= t;
    pc_low_data <= d;
    @(posedge clock);
    exec <= 0;
    #1;
  endtask

  task dport(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    dp_wr <= w;
    dp_rd <= !w;
    dp_addr <= a;
    dp_wdata <= d;
    @(posedge clock);
    dp_wr <= 0;
    dp_rd <= 0;
    @(posedge clock);
    #1;
    rd = {24'h0, dp_rdata};
  endtask

  task t_reset;
    @(posedge clock);
    #1;
    chk("pc reset", 0, prog_addr);
    $display("reset test done");
  endtask

  task t_jump;
    repeat (3) core(op_next, 0, 0);
    chk("pc next", 3, prog_addr);
    bus(1, `OFF_PC_HIGH_LATCH, 32'h18);
    core(op_jump, 11'h123, 0);
    chk("pc jump", 13'h1923, prog_addr);
    chk("pc jump small", 13'h0923, prog_addr_small);
    epc = 13'h1923;
    $display("jump test done");
  endtask

  task t_stack;
    bus(1, `OFF_PC_HIGH_LATCH, 32'h08);
    for (int i = 0; i < 9; i++) begin
      estk[esp] = epc + 1;
      esp++;
      epc = {2'b01, 11'h100 + 11'(i)};
      core(op_call, 11'h100 + 11'(i), 0);
      chk("pc call", epc, prog_addr);
    end
    for (int i = 0; i < 10; i++) begin
      esp--;
      epc = estk[esp];
      core(rets[i % 3], 0, 0);
      chk("pc return", epc, prog_addr);
    end
    bus(0, `OFF_PC_HIGH_LATCH, 0);
    chk("latch", 32'h08, rd);
    $display("stack test done");
  endtask

  task t_irq;
    estk[esp] = epc;
    esp++;
    core(op_interrupt, 0, 0);
    chk("pc vector", `IRQ_VECTOR, prog_addr);
    core(op_next, 0, 0);
    chk("pc isr", `IRQ_VECTOR + 1, prog_addr);
    esp--;
    core(op_return_from_interrupt, 0, 0);
    chk("pc resume", estk[esp], prog_addr);
    // Call and return in adjacent instructions.
    epc = estk[esp] + 13'h1;
    @(posedge clock);
    exec <= 1'b1;
    op <= op_call;
    target <= 11'h055;
    @(posedge clock);
    op <= op_return;
    @(posedge clock);
    exec <= 1'b0;
    #1;
    chk("pc call return", epc, prog_addr);
    $display("interrupt test done");
  endtask

  task t_pcl;
    bus(1, `OFF_PC_HIGH_LATCH, 32'h15);
    core(op_pc_low_write, 0, 8'h3c);
    chk("pc computed", 13'h153c, prog_addr);
    chk("pc computed small", 13'h053c, prog_addr_small);
    bus(1, `OFF_PC_LOW_BYTE, 32'h7e);
    #1;
    chk("pc bus", 13'h157e, prog_addr);
    bus(0, `OFF_PC_LOW_BYTE, 0);
    chk("pc low read", 32'h7e, rd);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, rd);
    $display("low byte test done");
  endtask

  task t_ind;
    int base;
    bus(1, `OFF_FILE_POINTER, 32'h25);
    bus(1, `OFF_BANK_STATUS, 32'h80);
    dport(0, 9'h000, 0);
    chk("ind read", 32'h80, rd);
    dport(1, 9'h000, 8'h3e);
    dport(0, 9'h000, 0);
    chk("ind write", 32'h3e, rd);
    bus(1, `OFF_FILE_POINTER, 32'h80);
    bus(1, `OFF_BANK_STATUS, 32'h00);
    base = n_rfwr;
    dport(1, 9'h000, 8'h55);
    dport(0, 9'h000, 0);
    chk("self read", 0, rd);
    chk("self write", base, n_rfwr);
    $display("indirect test done");
  endtask

  initial begin
    {exec, dp_rd, dp_wr, avs_read, avs_write} = 0;
    op = op_next;
    {target, pc_low_data, dp_wdata, dp_addr, avs_address, avs_writedata} = 0;
    avs_byteenable = 4'hf;
    rst = 1;
    esp = 0;
    repeat (6) @(posedge clock);
    rst <= 0;
    t_reset;
    t_jump;
    t_stack;
    t_irq;
    t_pcl;
    t_ind;
    test_done;
  end
endmodule
`default_nettype wire
